// >>> dv/sef_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sef_host_model (
  // Serial link to the device
  output logic sck_link,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so_o,
  input wire logic so_oe
);
  logic oe_pause = 1'b0;
  logic oe_back = 1'b0;

  // Mode 0: clock rests low between frames
  initial begin
    sck_link = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  task automatic begin_frame;
    cs_n = 1'b0;
    #40;
  endtask

  task automatic end_frame;
    #40;
    cs_n = 1'b1;
    // Released data line must not keep its last value
    si = ~si;
    #80;
  endtask

  task automatic xfer(input int nbits, input int pause_at, input logic [7:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      si = tx[7-i];
      if (i == pause_at) begin
        #10 hold_n = 1'b0;
        // A stray pulse while paused must be ignored
        #20 si = ~si;
        #20 sck_link = 1'b1;
        #40 sck_link = 1'b0;
        oe_pause = so_oe;
        si = tx[7-i];
        #20 hold_n = 1'b1;
        #30 oe_back = so_oe;
      end
      #40 sck_link = 1'b1;
      // Released output reads as the pull-up level
      rx = {rx[6:0], so_oe ? so_o : 1'b1};
      #40 sck_link = 1'b0;
    end
  endtask
endmodule // sef_host_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic wp_n = 1'b1;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic write_seq_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] status_byte = 8'h00;
  logic [7:0] rd;
  wire logic sck_link, cs_n, si, hold_n;
  logic so_o, so_oe, rx_first, rx_valid, tx_ready;
  logic sreg_write_ok, write_busy, standby, powerup_ready;
  logic [7:0] rx_data;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int busy_cyc = 0;
  int n;
  // Rows: write-protect pin, protect enable, status writes allowed
  logic [2:0] rows [4] = '{3'b101, 3'b111, 3'b001, 3'b010};

  always #12.5 clk = ~clk;

  sef_frontend #(.WRITE_CYCLES(50), .POWERUP_CYCLES(20)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .sck_link(sck_link), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe), .rx_data(rx_data),
    .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .status_byte(status_byte),
    .write_seq_valid(write_seq_valid), .sreg_write_ok(sreg_write_ok),
    .write_busy(write_busy), .standby(standby), .powerup_ready(powerup_ready));

  sef_host_model u_host (.sck_link(sck_link), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .so_o(so_o), .so_oe(so_oe));

  task automatic give_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic get_rx(input logic [7:0] d, input logic f);
    n = 0;
    while (rx_valid !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(8'(rx_valid), 8'h01);
    chk(rx_data, d);
    chk(8'(rx_first), 8'(f));
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask

  // Busy length counted where the flop output is settled
  always @(negedge clk) begin
    if (write_busy === 1'b1) begin
      busy_cyc <= busy_cyc + 1;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    // A real rising edge, so the link-side flops see their reset
    #1 sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    chk(8'(rx_valid), 8'h00);
    chk(8'(write_busy), 8'h00);
    chk(8'(standby), 8'h01);
    chk(8'(so_oe), 8'h00);
    chk(8'(powerup_ready), 8'h00);
    tick(25);
    chk(8'(powerup_ready), 8'h01);
    for (int i = 0; i < 4; i++) begin
      wp_n = rows[i][2];
      status_byte = {rows[i][1], 7'h00};
      tick(6);
      chk(8'(sreg_write_ok), 8'(rows[i][0]));
    end
    wp_n = 1'b1;
    status_byte = 8'h00;
    // Offer the reply byte before the frame opens
    tx_data = 8'h3c;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    tick(1);
    tx_valid = 1'b0;
    chk(8'(tx_ready), 8'h00);
    u_host.begin_frame();
    u_host.xfer(8, -1, 8'ha5, rd);
    u_host.xfer(8, 3, 8'h5a, rd);
    u_host.end_frame();
    chk(rd, 8'h3c);
    chk(8'(u_host.oe_pause), 8'h00);
    chk(8'(u_host.oe_back), 8'h01);
    tick(5);
    chk(8'(so_oe), 8'h00);
    chk(8'(standby), 8'h01);
    chk(8'(tx_ready), 8'h01);
    get_rx(8'ha5, 1'b1);
    get_rx(8'h5a, 1'b0);
    // Broken byte, then a fresh frame
    u_host.begin_frame();
    u_host.xfer(4, -1, 8'hff, rd);
    u_host.end_frame();
    u_host.begin_frame();
    u_host.xfer(8, -1, 8'h81, rd);
    u_host.end_frame();
    get_rx(8'h81, 1'b1);
    write_seq_valid = 1'b1;
    u_host.begin_frame();
    u_host.xfer(8, -1, 8'h02, rd);
    u_host.end_frame();
    tick(1);
    n = 0;
    while (write_busy !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(8'(standby), 8'h00);
    n = 0;
    while (write_busy === 1'b1 && n < 100) begin
      n++;
      tick(1);
    end
    chk(8'(busy_cyc), 8'h32);
    write_seq_valid = 1'b0;
    get_rx(8'h02, 1'b1);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire

// >>> hdl/sef_consts.svh
`ifndef SEF_CONSTS_SVH
`define SEF_CONSTS_SVH
`define SEF_CLK_PERIOD_NS 25
`define SEF_WC_TIME_MS 5
`define SEF_PU_TIME_MS 1
`define SEF_WC_CYCLES ((`SEF_WC_TIME_MS * 1000000) / `SEF_CLK_PERIOD_NS)
`define SEF_PU_CYCLES ((`SEF_PU_TIME_MS * 1000000) / `SEF_CLK_PERIOD_NS)
`define SEF_CNT_W 20
`define SEF_HPE_BIT 7
`define SEF_BYTE_W 8
`define SEF_FIFO_DEPTH 4
`define SEF_BIT_LAST 3'h7
`define SEF_SYNC_RST 4'h8
`endif

// >>> hdl/sef_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sef_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Streams
  sef_stream_if.snk in_s,
  sef_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  always_comb begin
    push = in_s.valid && (cnt_ff != (AW+1)'(DEPTH));
    pop = out_s.ready && (cnt_ff != '0);
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_s.data;
    end
  end

  assign in_s.ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data = mem_ff[rd_ff];
endmodule // sef_fifo
`default_nettype wire

// >>> hdl/sef_frontend.sv
// Function
// - Serial input bits are captured on each rising serial clock edge.
// - Serial output advances to the next bit on each falling clock edge.
// - Serial output is released whenever select is high.
// - Select high gives standby, but a running write cycle completes.
// - Write-protect input high never blocks any write once it has passed the synchronizer, which resets low.
// - Write-protect low with protect enable set refuses status writes.
// - Pause low freezes the transaction; pause high resumes where it stopped.
// - Serial output is released while a pause is in effect.
// - Serial output is driven again once the pause ends.
// - Internal write cycle lasts 5 ms, starting at the third clock edge after select rising.
// - Protect enable is status bit 7 and qualifies the write-protect input.
`include "sef_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sef_frontend import sef_pkg::*; #(
  parameter int WRITE_CYCLES = `SEF_WC_CYCLES,
  parameter int POWERUP_CYCLES = `SEF_PU_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic sck_link,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe,
  // Received bytes
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_valid,
  input wire logic rx_ready,
  // Byte to send
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Protection and write cycle
  input wire logic [7:0] status_byte,
  input wire logic write_seq_valid,
  output logic sreg_write_ok,
  output logic write_busy,
  output logic standby,
  output logic powerup_ready
);
  // Link side, cleared only by system reset
  sef_rx_t rx_word_ff, nxt_rx_word;
  logic rx_tgl_ff, nxt_rx_tgl;
  logic tx_ack_ff, nxt_tx_ack;
  logic [7:0] tx_word_ff, nxt_tx_word;
  logic txs_m_ff, txs_s_ff;
  // Link side, cleared by every select rise
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [6:0] rx_sh_ff, nxt_rx_sh;
  logic first_ff, nxt_first;
  logic drive_ff, nxt_drive;
  logic so_ff, nxt_so;
  logic byte_end;
  // Core side
  logic tx_tgl_ff, nxt_tx_tgl;
  logic [7:0] tx_hold_ff, nxt_tx_hold;
  logic tx_ready_ff, nxt_tx_ready;
  logic rx_seen_ff, nxt_rx_seen;
  sef_rx_t out_ff, nxt_out;
  logic out_vld_ff, nxt_out_vld;
  sef_state_t state_ff, nxt_state;
  logic [`SEF_CNT_W-1:0] wc_cnt_ff, nxt_wc_cnt;
  logic [`SEF_CNT_W-1:0] pu_cnt_ff, nxt_pu_cnt;
  logic pu_rdy_ff, nxt_pu_rdy;
  logic sr_ok_ff, nxt_sr_ok;
  logic busy_ff, nxt_busy;
  logic stby_ff, nxt_stby;
  logic cs_s, wp_s, rx_tgl_s, tx_ack_s;
  logic pop;

  sef_stream_if #(.W(9)) fill_s ();
  sef_stream_if #(.W(9)) drain_s ();

  // Link logic: capture on rise, shift out on fall
  always_comb begin
    byte_end = hold_n && (bit_cnt_ff == `SEF_BIT_LAST);
    nxt_bit_cnt = bit_cnt_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_first = first_ff;
    nxt_drive = drive_ff;
    nxt_rx_word = rx_word_ff;
    nxt_rx_tgl = rx_tgl_ff;
    nxt_tx_word = tx_word_ff;
    nxt_tx_ack = tx_ack_ff;
    if (hold_n) begin
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      nxt_rx_sh = {rx_sh_ff[5:0], si};
    end
    if (byte_end) begin
      nxt_rx_word = '{first: first_ff, data: {rx_sh_ff, si}};
      nxt_rx_tgl = ~rx_tgl_ff;
      nxt_first = 1'b0;
      // Word is stable: core side waits for this acknowledge
      if (txs_s_ff != tx_ack_ff) begin
        nxt_tx_word = tx_hold_ff;
        nxt_tx_ack = txs_s_ff;
        nxt_drive = 1'b1;
      end
    end
    nxt_so = hold_n ? tx_word_ff[~bit_cnt_ff] : so_ff;
  end

  always_ff @(posedge sck_link or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word_ff <= '0;
      rx_tgl_ff <= 1'b0;
      tx_word_ff <= 8'h00;
      tx_ack_ff <= 1'b0;
      txs_m_ff <= 1'b0;
      txs_s_ff <= 1'b0;
    end else begin
      rx_word_ff <= nxt_rx_word;
      rx_tgl_ff <= nxt_rx_tgl;
      tx_word_ff <= nxt_tx_word;
      tx_ack_ff <= nxt_tx_ack;
      txs_m_ff <= tx_tgl_ff;
      txs_s_ff <= txs_m_ff;
    end
  end

  // System reset also clears frame state, so power-up never leaves it unknown
  always_ff @(posedge sck_link or posedge cs_n or posedge sys_rst) begin
    if (cs_n || sys_rst) begin
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 7'h00;
      first_ff <= 1'b1;
      drive_ff <= 1'b0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      rx_sh_ff <= nxt_rx_sh;
      first_ff <= nxt_first;
      drive_ff <= nxt_drive;
    end
  end

  // Output flop needs a defined value before the first frame as well
  always_ff @(negedge sck_link or posedge cs_n or posedge sys_rst) begin
    if (cs_n || sys_rst) begin
      so_ff <= 1'b0;
    end else begin
      so_ff <= nxt_so;
    end
  end

  // Enable must follow the pins at once, so it is gated outside the flop
  assign so_oe = drive_ff && !cs_n && hold_n;
  assign so_o = so_ff;

  sef_sync #(.W(4), .RST_VAL(`SEF_SYNC_RST)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({cs_n, wp_n, rx_tgl_ff, tx_ack_ff}),
    .q({cs_s, wp_s, rx_tgl_s, tx_ack_s})
  );

  // A byte arriving while the FIFO is full waits; a second one overruns it
  assign fill_s.valid = (rx_tgl_s != rx_seen_ff);
  assign fill_s.data = rx_word_ff;
  assign pop = drain_s.valid && (!out_vld_ff || rx_ready);
  assign drain_s.ready = pop;

  sef_fifo #(.W(9), .DEPTH(`SEF_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // Core side: stream, handshake, write timer, protection
  always_comb begin
    nxt_rx_seen = (fill_s.valid && fill_s.ready) ? rx_tgl_s : rx_seen_ff;
    nxt_out = pop ? sef_rx_t'(drain_s.data) : out_ff;
    nxt_out_vld = pop || (out_vld_ff && !rx_ready);
    nxt_tx_tgl = tx_tgl_ff;
    nxt_tx_hold = tx_hold_ff;
    if (tx_valid && tx_ready_ff) begin
      nxt_tx_tgl = ~tx_tgl_ff;
      nxt_tx_hold = tx_data;
    end
    nxt_tx_ready = (tx_ack_s == nxt_tx_tgl);
    nxt_state = state_ff;
    nxt_wc_cnt = wc_cnt_ff;
    case (state_ff)
      SEF_IDLE: begin
        if (!cs_s) begin
          nxt_state = SEF_FRAME;
        end
      end
      SEF_FRAME: begin
        if (cs_s) begin
          nxt_state = write_seq_valid ? SEF_WRITE : SEF_IDLE;
          nxt_wc_cnt = '0;
        end
      end
      SEF_WRITE: begin
        // Select is ignored until the cycle is done
        nxt_wc_cnt = wc_cnt_ff + 1'b1;
        if (wc_cnt_ff == `SEF_CNT_W'(WRITE_CYCLES - 1)) begin
          nxt_state = SEF_IDLE;
        end
      end
      default: begin
        nxt_state = SEF_IDLE;
      end
    endcase
    nxt_busy = (nxt_state == SEF_WRITE);
    nxt_stby = cs_s && (nxt_state != SEF_WRITE);
    nxt_sr_ok = wp_s || !status_byte[`SEF_HPE_BIT];
    nxt_pu_rdy = pu_rdy_ff || (pu_cnt_ff == `SEF_CNT_W'(POWERUP_CYCLES - 1));
    nxt_pu_cnt = pu_rdy_ff ? pu_cnt_ff : pu_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_seen_ff <= 1'b0;
      out_ff <= '0;
      out_vld_ff <= 1'b0;
      tx_tgl_ff <= 1'b0;
      tx_hold_ff <= 8'h00;
      tx_ready_ff <= 1'b0;
      state_ff <= SEF_IDLE;
      wc_cnt_ff <= '0;
      busy_ff <= 1'b0;
      stby_ff <= 1'b1;
      sr_ok_ff <= 1'b1;
      pu_cnt_ff <= '0;
      pu_rdy_ff <= 1'b0;
    end else begin
      rx_seen_ff <= nxt_rx_seen;
      out_ff <= nxt_out;
      out_vld_ff <= nxt_out_vld;
      tx_tgl_ff <= nxt_tx_tgl;
      tx_hold_ff <= nxt_tx_hold;
      tx_ready_ff <= nxt_tx_ready;
      state_ff <= nxt_state;
      wc_cnt_ff <= nxt_wc_cnt;
      busy_ff <= nxt_busy;
      stby_ff <= nxt_stby;
      sr_ok_ff <= nxt_sr_ok;
      pu_cnt_ff <= nxt_pu_cnt;
      pu_rdy_ff <= nxt_pu_rdy;
    end
  end

  assign rx_data = out_ff.data;
  assign rx_first = out_ff.first;
  assign rx_valid = out_vld_ff;
  assign tx_ready = tx_ready_ff;
  assign sreg_write_ok = sr_ok_ff;
  assign write_busy = busy_ff;
  assign standby = stby_ff;
  assign powerup_ready = pu_rdy_ff;

  a_rx_capture: assert property (@(posedge sck_link) disable iff (cs_n || sys_rst)
    byte_end |=> rx_word_ff.data[0] == $past(si))
    else $error("last bit of byte not taken from serial input");
  a_hold_freeze: assert property (@(posedge sck_link) disable iff (cs_n || sys_rst)
    !hold_n |=> bit_cnt_ff == $past(bit_cnt_ff))
    else $error("bit counter moved during pause");
  a_oe_select: assert property (@(posedge clk) disable iff (sys_rst)
    cs_n |-> !so_oe && bit_cnt_ff == 3'h0)
    else $error("output driven or counter set while deselected");
  a_oe_pause: assert property (@(posedge clk) disable iff (sys_rst)
    !hold_n |-> !so_oe)
    else $error("output driven during pause");
  a_oe_resume: assert property (@(posedge sck_link) disable iff (sys_rst)
    (drive_ff && !cs_n && $rose(hold_n)) |-> so_oe)
    else $error("output not driven after pause");
  a_wc_bound: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == SEF_WRITE |-> wc_cnt_ff < `SEF_CNT_W'(WRITE_CYCLES))
    else $error("write cycle overran its bound");
  a_wc_start: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == SEF_FRAME && cs_s && write_seq_valid) |=> busy_ff && !stby_ff)
    else $error("write cycle did not start at select rise");
  a_sr_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    (!wp_s && status_byte[`SEF_HPE_BIT]) |=> !sr_ok_ff)
    else $error("status write not refused");
  a_sr_allow: assert property (@(posedge clk) disable iff (sys_rst)
    wp_s |=> sr_ok_ff)
    else $error("status write blocked with protect input high");
  c_write_cycle: cover property (@(posedge clk) disable iff (sys_rst)
    busy_ff ##1 !busy_ff);
  c_rx_full: cover property (@(posedge clk) disable iff (sys_rst)
    fill_s.valid && !fill_s.ready);
  c_pause_frame: cover property (@(posedge sck_link) disable iff (sys_rst)
    !cs_n && !hold_n ##1 hold_n);
  // Reply byte picked up at a byte boundary
  c_tx_load: cover property (@(posedge sck_link) disable iff (sys_rst)
    byte_end && (txs_s_ff != tx_ack_ff));
endmodule // sef_frontend
`default_nettype wire

// >>> hdl/sef_pkg.sv
package sef_pkg;
  typedef enum logic [1:0] {
    SEF_IDLE = 2'h0,
    SEF_FRAME = 2'h1,
    SEF_WRITE = 2'h3
  } sef_state_t;
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } sef_rx_t;
endpackage

// >>> hdl/sef_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sef_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> hdl/sef_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sef_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_ff[i] <= RST_VAL[i];
          q_ff[i] <= RST_VAL[i];
        end else begin
          meta_ff[i] <= d[i];
          q_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
  assign q = q_ff;
endmodule // sef_sync
`default_nettype wire
